// ---- rtl/dual_comparator_control.sv ----
/*
 * Dual comparator control: configuration register, result reporting,
 * routing of comparator inputs and outputs to port bits, change detection.
 * Assumes raw comparator results are asynchronous, port pins and analog
 * muxes outside; AXI4-Lite master drives the register bus.
 */
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps

// Contract
// - The 8-bit config register at 9Ch has read-only result bits 7:6, writable bits 5:0, all zero at reset.
// - A raw result is one when plus input exceeds minus input; comparator 2 at bit 7, comparator 1 at bit 6.
// - Each reported result is the raw result XOR its polarity bit, bit 5 for comparator 2, bit 4 for 1.
// - The mode field in bits 2:0 picks one of eight routings and whether outputs reach pins.
// - The input switch at bit 3 picks alternate pin pairs, or reference versus pin in one mode.
// - Inputs come from port bits 3:0 and outputs may go to port bits 5:4 by mode.
// - A port pin used as analog input reads zero on its digital path.
// - After a mode change the results are flagged unreliable for a settling interval.
// - A change flag is set while a reported result differs from its latched copy.
// - Any read or write of the config register updates the latched copy, ending the mismatch unless a write flips a polarity bit.
module dual_comparator_control
    import comparator_config_pkg::*;
#(
    parameter int SETTLE_COUNT = SETTLE_CYCLES
) (
    input  wire logic        clk,
    input  wire logic        rstn,
    // AXI4-Lite slave
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Analog side
    input  wire logic        firstRaw,
    input  wire logic        secondRaw,
    output logic [2:0]       routingMode,
    output logic             inputSwitch,
    output logic             useReference,
    // Port side
    input  wire logic [3:0]  portDigitalIn,
    output logic [3:0]       portReadValue,
    output logic [3:0]       analogPinMask,
    output logic [1:0]       outputPinEnable,
    output logic [1:0]       outputPinValue,
    // Change flags and clears
    input  wire logic [1:0]  changeFlagClear,
    output logic [1:0]       changeFlag,
    output logic             resultsSettling
);

    // Settling counter is 16 bits wide
    if (SETTLE_COUNT < 1 || SETTLE_COUNT > 65535) begin : g_bad_settle
        $error("SETTLE_COUNT out of range");
    end

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic [5:0]  ctrl_q;
    logic [1:0]  syncA_q;
    logic [1:0]  syncB_q;
    logic [1:0]  latched_q;
    logic [1:0]  flag_q;
    logic [15:0] settle_q;
    bus_state_t  wrState_q;
    bus_state_t  rdState_q;
    logic [1:0]  bresp_q;
    logic [31:0] rdata_q;
    logic [1:0]  rresp_q;
    logic        awHeld_q;
    logic        wHeld_q;
    logic [7:0]  awAddr_q;
    logic [31:0] wData_q;
    logic [3:0]  wStrb_q;

    logic [1:0]  reported;
    logic        wrFire;
    logic        rdFire;
    logic        cfgAccess;
    logic [7:0]  cfgRead;
    logic [7:0]  newCtrl;
    logic        wrCfg;
    logic        wrStatus;
    logic        rdCfg;
    logic        rdStatus;
    logic        modeChange;

    function automatic logic [3:0] analog_pins(input logic [2:0] m, input logic sw);
        unique case (m)
            3'd0:    analog_pins = 4'hF;
            3'd1:    analog_pins = sw ? 4'hF : 4'hF;
            3'd2:    analog_pins = 4'hF;
            3'd3:    analog_pins = 4'hB;
            3'd4:    analog_pins = 4'h3;
            3'd5:    analog_pins = 4'h2;
            3'd6:    analog_pins = 4'h3;
            default: analog_pins = 4'h0;
        endcase
    endfunction

    function automatic logic [1:0] output_pins(input logic [2:0] m);
        unique case (m)
            3'd6:    output_pins = 2'b11;
            default: output_pins = 2'b00;
        endcase
    endfunction

    // ------------------------------------------------------------
    // Synchroniser and results
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            syncA_q <= 2'b00;
            syncB_q <= 2'b00;
        end else begin
            syncA_q <= {secondRaw, firstRaw};
            syncB_q <= syncA_q;
        end
    end

    // Raw one means plus exceeds minus; XOR with polarity
    assign reported = syncB_q ^ {ctrl_q[SECOND_POLARITY_POS], ctrl_q[FIRST_POLARITY_POS]};
    assign cfgRead  = {reported, ctrl_q};

    // ------------------------------------------------------------
    // Routing
    // ------------------------------------------------------------
    assign routingMode     = ctrl_q[MODE_LSB +: MODE_WIDTH];
    assign inputSwitch     = ctrl_q[INPUT_SWITCH_POS];
    assign useReference    = (routingMode == 3'd2) && !inputSwitch;
    assign analogPinMask   = analog_pins(routingMode, inputSwitch);
    assign portReadValue   = portDigitalIn & ~analogPinMask;
    assign outputPinEnable = output_pins(routingMode);
    assign outputPinValue  = outputPinEnable & reported;

    // ------------------------------------------------------------
    // AXI4-Lite write
    // ------------------------------------------------------------
    assign s_axi_awready = (wrState_q == BUS_IDLE) && !awHeld_q;
    assign s_axi_wready  = (wrState_q == BUS_IDLE) && !wHeld_q;
    assign s_axi_bvalid  = (wrState_q == BUS_RESP);
    assign s_axi_bresp   = bresp_q;
    assign wrFire = (wrState_q == BUS_IDLE) && (awHeld_q || s_axi_awvalid) && (wHeld_q || s_axi_wvalid);

    logic [7:0]  wrAddr;
    logic [31:0] wrData;
    logic [3:0]  wrStrb;
    assign wrAddr = awHeld_q ? awAddr_q : s_axi_awaddr;
    assign wrData = wHeld_q ? wData_q : s_axi_wdata;
    assign wrStrb = wHeld_q ? wStrb_q : s_axi_wstrb;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wrState_q <= BUS_IDLE;
            awHeld_q  <= 1'b0;
            wHeld_q   <= 1'b0;
            awAddr_q  <= 8'h00;
            wData_q   <= 32'h0;
            wStrb_q   <= 4'h0;
            bresp_q   <= RESP_OKAY;
        end else begin
            unique case (wrState_q)
                BUS_IDLE: begin
                    if (wrFire) begin
                        wrState_q <= BUS_RESP;
                        awHeld_q  <= 1'b0;
                        wHeld_q   <= 1'b0;
                        bresp_q   <= (wrAddr == CONFIG_OFFSET || wrAddr == STATUS_OFFSET) ? RESP_OKAY : RESP_SLVERR;
                    end else begin
                        if (s_axi_awvalid && !awHeld_q) begin
                            awHeld_q <= 1'b1;
                            awAddr_q <= s_axi_awaddr;
                        end
                        if (s_axi_wvalid && !wHeld_q) begin
                            wHeld_q <= 1'b1;
                            wData_q <= s_axi_wdata;
                            wStrb_q <= s_axi_wstrb;
                        end
                    end
                end
                BUS_RESP: begin
                    if (s_axi_bready) begin
                        wrState_q <= BUS_IDLE;
                    end
                end
                default: wrState_q <= BUS_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    assign wrCfg      = wrFire && (wrAddr == CONFIG_OFFSET) && wrStrb[0];
    assign wrStatus   = wrFire && (wrAddr == STATUS_OFFSET) && wrStrb[0];
    assign rdCfg      = rdFire && (s_axi_araddr == CONFIG_OFFSET);
    assign rdStatus   = rdFire && (s_axi_araddr == STATUS_OFFSET);
    assign newCtrl    = (wrData[7:0] & CONFIG_WR_MASK) | ({2'b00, ctrl_q} & ~CONFIG_WR_MASK);
    assign modeChange = wrCfg && (newCtrl[MODE_LSB +: MODE_WIDTH] != routingMode);

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ctrl_q <= CONFIG_RESET[5:0];
        end else if (wrCfg) begin
            ctrl_q <= newCtrl[5:0];
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite read
    // ------------------------------------------------------------
    assign s_axi_arready = (rdState_q == BUS_IDLE);
    assign s_axi_rvalid  = (rdState_q == BUS_RESP);
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;
    assign rdFire = (rdState_q == BUS_IDLE) && s_axi_arvalid;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rdState_q <= BUS_IDLE;
            rdata_q   <= 32'h0;
            rresp_q   <= RESP_OKAY;
        end else begin
            unique case (rdState_q)
                BUS_IDLE: begin
                    if (rdFire) begin
                        rdState_q <= BUS_RESP;
                        rresp_q   <= RESP_OKAY;
                        if (rdCfg) begin
                            rdata_q <= {24'h0, cfgRead};
                        end else if (rdStatus) begin
                            rdata_q <= {29'h0, flag_q, resultsSettling};
                        end else begin
                            rdata_q <= 32'h0;
                            rresp_q <= RESP_SLVERR;
                        end
                    end
                end
                BUS_RESP: begin
                    if (s_axi_rready) begin
                        rdState_q <= BUS_IDLE;
                    end
                end
                default: rdState_q <= BUS_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Change detection
    // ------------------------------------------------------------
    assign cfgAccess = rdCfg || (wrFire && wrAddr == CONFIG_OFFSET);

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            latched_q <= 2'b00;
        end else if (cfgAccess) begin
            latched_q <= reported;
        end
    end

    // Set wins over clear; bus write of one to status clears too
    logic [1:0] busClear;
    assign busClear = wrStatus ? wrData[2:1] : 2'b00;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            flag_q <= 2'b00;
        end else begin
            flag_q <= (flag_q & ~(changeFlagClear | busClear)) | (reported ^ latched_q);
        end
    end
    assign changeFlag = flag_q;

    // ------------------------------------------------------------
    // Settling after mode change
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            settle_q <= 16'h0;
        end else if (modeChange) begin
            settle_q <= 16'(SETTLE_COUNT);
        end else if (settle_q != 16'h0) begin
            settle_q <= settle_q - 16'h1;
        end
    end
    assign resultsSettling = (settle_q != 16'h0);

endmodule

// ---- include/comparator_config_pkg.sv ----
/*
 * Package for the dual comparator control block: register offsets, field
 * positions, reset value and timing counts.
 * Assumes a 10 MHz core clock and a 32-bit AXI4-Lite register bus.
 */
package comparator_config_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0]  CONFIG_OFFSET   = 8'h9C;
    localparam logic [7:0]  STATUS_OFFSET   = 8'hA0;
    localparam logic [7:0]  CONFIG_RESET    = 8'h00;
    localparam logic [7:0]  CONFIG_WR_MASK  = 8'h3F;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int SECOND_RESULT_POS   = 7;
    localparam int FIRST_RESULT_POS    = 6;
    localparam int SECOND_POLARITY_POS = 5;
    localparam int FIRST_POLARITY_POS  = 4;
    localparam int INPUT_SWITCH_POS    = 3;
    localparam int MODE_LSB            = 0;
    localparam int MODE_WIDTH          = 3;

    // Status register bits
    localparam int STAT_SETTLING_POS   = 0;
    localparam int STAT_FIRST_CHG_POS  = 1;
    localparam int STAT_SECOND_CHG_POS = 2;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_HZ          = 10_000_000;
    localparam int SETTLE_NS       = 10_000;
    localparam int SETTLE_CYCLES   = (SETTLE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

    // AXI responses
    localparam logic [1:0]  RESP_OKAY   = 2'b00;
    localparam logic [1:0]  RESP_SLVERR = 2'b10;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_RESP = 2'b10
    } bus_state_t;

endpackage

// ---- dv/comparator_core_model.sv ----
/* Behavioural pair of analog comparators on the far side of the block.
   Assumes the bench drives the input levels; results change off the clock. */
`timescale 1ns/1ps
module comparator_core_model (
    input  wire logic [7:0] firstPlus,
    input  wire logic [7:0] firstMinus,
    input  wire logic [7:0] secondPlus,
    input  wire logic [7:0] secondMinus,
    output logic            firstRaw,
    output logic            secondRaw
);
    // High only when plus exceeds minus
    assign #7 firstRaw  = firstPlus > firstMinus;
    assign #7 secondRaw = secondPlus > secondMinus;
endmodule

// ---- dv/dual_comparator_control_props.sv ----
/* Port checker for the dual comparator control block.
   Assumes it is bound to dual_comparator_control; clk and active-low rstn. */
`timescale 1ns/1ps
module dual_comparator_control_props
    import comparator_config_pkg::*;
#(
    parameter int SETTLE_COUNT = SETTLE_CYCLES
) (
    input wire logic       clk,
    input wire logic       rstn,
    input wire logic       s_axi_awvalid,
    input wire logic       s_axi_awready,
    input wire logic       s_axi_wvalid,
    input wire logic       s_axi_wready,
    input wire logic       s_axi_bvalid,
    input wire logic       s_axi_arvalid,
    input wire logic       s_axi_arready,
    input wire logic       s_axi_rvalid,
    input wire logic       firstRaw,
    input wire logic [2:0] routingMode,
    input wire logic       inputSwitch,
    input wire logic       useReference,
    input wire logic [3:0] portDigitalIn,
    input wire logic [3:0] portReadValue,
    input wire logic [3:0] analogPinMask,
    input wire logic [1:0] outputPinEnable,
    input wire logic [1:0] outputPinValue,
    input wire logic [1:0] changeFlagClear,
    input wire logic [1:0] changeFlag,
    input wire logic       resultsSettling
);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    int unsigned settleCnt_q;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn)
            settleCnt_q <= 0;
        else
            settleCnt_q <= resultsSettling ? settleCnt_q + 1 : 0;
    end
    sequence s_write_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_read_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    a_write_answer: assert property (s_write_taken |=> s_axi_bvalid)
        else $error("write not answered");
    a_read_answer: assert property (s_read_taken |=> s_axi_rvalid)
        else $error("read not answered");
    a_analog_reads_zero: assert property (portReadValue == (portDigitalIn & ~analogPinMask))
        else $error("analog pin leaks digital level");
    a_mode_all_digital: assert property (routingMode == 3'h7 |-> analogPinMask == 4'h0)
        else $error("digital mode has analog pins");
    a_mode_all_analog: assert property (routingMode <= 3'h2 |-> analogPinMask == 4'hF)
        else $error("analog mode misses pins");
    a_reference_pick: assert property (useReference == (routingMode == 3'h2 && !inputSwitch))
        else $error("reference selection wrong");
    a_pin_drive: assert property (outputPinEnable == ((routingMode == 3'h6) ? 2'h3 : 2'h0))
        else $error("output pin enable wrong");
    a_mode_settle: assert property ($changed(routingMode) |-> ##[0:1] resultsSettling)
        else $error("no settling after mode change");
    a_settle_length: assert property (settleCnt_q <= SETTLE_COUNT)
        else $error("settling too long");
    a_sync_delay: assert property ($changed(firstRaw) && routingMode == 3'h6 |=> $stable(outputPinValue[0]))
        else $error("raw result not synchronised");
    a_flag_hold: assert property (changeFlag[0] && !changeFlagClear[0] && !s_axi_wvalid |=> changeFlag[0])
        else $error("change flag dropped");
endmodule
bind dual_comparator_control dual_comparator_control_props #(.SETTLE_COUNT(SETTLE_COUNT)) u_props (
    .clk, .rstn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .firstRaw, .routingMode, .inputSwitch, .useReference,
    .portDigitalIn, .portReadValue, .analogPinMask, .outputPinEnable, .outputPinValue, .changeFlagClear,
    .changeFlag, .resultsSettling
);

// ---- dv/tb.sv ----
/* Self-checking bench for the dual comparator control block.
   Assumes the comparator model and the bound checker are compiled with it. */
`timescale 1ns/1ps
module tb;
    import comparator_config_pkg::*;
    localparam int SETTLE = 4;
    logic        clk, rstn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic        firstRaw, secondRaw, inputSwitch, useReference, resultsSettling;
    logic [7:0]  s_axi_awaddr, s_axi_araddr, firstPlus, firstMinus, secondPlus, secondMinus;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0]  s_axi_wstrb, portDigitalIn, portReadValue, analogPinMask;
    logic [2:0]  routingMode;
    logic [1:0]  s_axi_bresp, s_axi_rresp, outputPinEnable, outputPinValue, changeFlagClear, changeFlag, rsp;
    int          fail_count = 0, checks = 0, cycles = 0;

    dual_comparator_control #(.SETTLE_COUNT(SETTLE)) u_dual_comparator_control (
        .clk, .rstn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .firstRaw, .secondRaw, .routingMode, .inputSwitch, .useReference, .portDigitalIn, .portReadValue,
        .analogPinMask, .outputPinEnable, .outputPinValue, .changeFlagClear, .changeFlag, .resultsSettling);
    comparator_core_model u_comparator_core_model (.firstPlus, .firstMinus, .secondPlus, .secondMinus,
        .firstRaw, .secondRaw);

    // ------------------------------------------------------------
    // Clock, timeout and helpers
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            fail_count++;
            finish_test();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic finish_test();
        if (fail_count == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic axiWrite(input logic [7:0] a, input logic [7:0] d);
        bit awBusy = 1;
        bit wBusy = 1;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h000000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (awBusy || wBusy) begin
            @(posedge clk);
            if (awBusy && s_axi_awready) begin
                awBusy = 0;
                s_axi_awvalid <= 1'b0;
            end
            if (wBusy && s_axi_wready) begin
                wBusy = 0;
                s_axi_wvalid <= 1'b0;
            end
        end
        while (!s_axi_bvalid) @(posedge clk);
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic axiRead(input logic [7:0] a);
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge clk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        while (!s_axi_rvalid) @(posedge clk);
        rd = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    function automatic logic [1:0] expRes(input logic [5:0] cfg);
        expRes[1] = (secondPlus > secondMinus) ^ cfg[5];
        expRes[0] = (firstPlus > firstMinus) ^ cfg[4];
    endfunction
    function automatic logic [3:0] expMask(input logic [2:0] m);
        case (m)
            3'h3:       expMask = 4'hB;
            3'h4, 3'h6: expMask = 4'h3;
            3'h5:       expMask = 4'h2;
            3'h7:       expMask = 4'h0;
            default:    expMask = 4'hF;
        endcase
    endfunction
    task automatic pulseClear();
        changeFlagClear <= 2'h3;
        @(posedge clk);
        changeFlagClear <= 2'h0;
        @(posedge clk);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        logic [5:0] cfg;
        void'($urandom(35961));
        {rstn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, portDigitalIn, changeFlagClear} = '0;
        {firstPlus, firstMinus, secondPlus, secondMinus} = '0;
        s_axi_wstrb = 4'h1;
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        axiRead(CONFIG_OFFSET);
        check(rd, 32'h00000000);
        for (int i = 0; i < 24; i++) begin
            cfg = 6'($urandom());
            cfg[2:0] = 3'(i + 1);
            axiWrite(CONFIG_OFFSET, {(i == 0) ? 2'b11 : 2'b00, cfg});
            check(rsp, RESP_OKAY);
            check(resultsSettling, 1'b1);
            check(routingMode, cfg[2:0]);
            check(inputSwitch, cfg[3]);
            firstPlus <= 8'($urandom());
            firstMinus <= 8'($urandom());
            secondPlus <= 8'($urandom());
            secondMinus <= 8'($urandom());
            portDigitalIn <= 4'($urandom());
            repeat (SETTLE + 4) @(posedge clk);
            check(outputPinValue, (cfg[2:0] == 3'h6) ? expRes(cfg) : 2'h0);
            check(resultsSettling, 1'b0);
            check(analogPinMask, expMask(cfg[2:0]));
            check(portReadValue, portDigitalIn & ~expMask(cfg[2:0]));
            check(outputPinEnable, (cfg[2:0] == 3'h6) ? 2'h3 : 2'h0);
            check(useReference, cfg[2:0] == 3'h2 && !cfg[3]);
            axiRead(CONFIG_OFFSET);
            check(rd, {24'h000000, expRes(cfg), cfg});
        end
        axiRead(8'h40);
        check(rsp, RESP_SLVERR);
        check(rd, 32'h00000000);
        axiWrite(8'h44, 8'h5A);
        check(rsp, RESP_SLVERR);
        axiWrite(CONFIG_OFFSET, 8'h07);
        {firstPlus, firstMinus, secondPlus, secondMinus} <= 32'h00FF00FF;
        axiRead(STATUS_OFFSET);
        check(rd[0], 1'b1);
        repeat (SETTLE + 4) @(posedge clk);
        axiRead(CONFIG_OFFSET);
        pulseClear(); // Stale flags from the earlier loop and level changes dropped
        check(changeFlag, 2'h0);
        {firstPlus, firstMinus} <= 16'hFF00;
        repeat (6) @(posedge clk);
        check(changeFlag, 2'h1);
        pulseClear();
        check(changeFlag, 2'h1);
        axiRead(STATUS_OFFSET);
        check(rd, 32'h00000002);
        axiRead(CONFIG_OFFSET);
        axiWrite(STATUS_OFFSET, 8'h06);
        check(rsp, RESP_OKAY);
        check(changeFlag, 2'h0);
        finish_test();
    end
endmodule
